// ### core/cbp_pkg.sv
package cbp_pkg;

   localparam int N_SLAVES   = 16;
   localparam int IMG_BYTES  = 8;
   localparam int DEV_BYTES  = 2;
   localparam int ID_BYTES   = 8;
   localparam int CHAN_BYTES = 3;

   // register offsets, one word each
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_MASK    = 8'h08;
   localparam logic [7:0] REG_DIAG_LO = 8'h0C;
   localparam logic [7:0] REG_DIAG_HI = 8'h10;
   localparam logic [7:0] REG_RELAY   = 8'h14;

   localparam int CTRL_MODE_BIT  = 0;
   localparam int CTRL_START_BIT = 1;
   localparam logic CTRL_MODE_RST = 1'b0;

   localparam int EV_W          = 4;
   localparam int EV_FRAME_ERR  = 0;
   localparam int EV_IMAGE_DONE = 1;
   localparam int EV_DIAG_DONE  = 2;
   localparam int EV_FAULT_RISE = 3;
   localparam logic [3:0] MASK_RST = 4'h0;

   // diagnostics byte 1 and byte 2 bit positions
   localparam int B1_GENERAL   = 7;
   localparam int B1_SLV_SUPPLY = 6;
   localparam int B1_COMM      = 4;
   localparam int B1_READY     = 2;
   localparam int B1_MASTER    = 0;
   localparam int B2_AUX       = 6;
   localparam int B2_TYPE      = 5;
   localparam int B2_BREAKER   = 3;
   localparam int B2_SDIAG     = 1;

   localparam int RELAY_BIT = 0;

   // channel entry codes
   localparam logic [7:0] ERR_NONE    = 8'h00;
   localparam logic [7:0] ERR_COMM    = 8'h01;
   localparam logic [7:0] ERR_TYPE    = 8'h02;
   localparam logic [7:0] ERR_BREAKER = 8'h03;
   localparam logic [7:0] ERR_SDIAG   = 8'h04;
   localparam logic [7:0] CHAN_TYPE   = 8'h08;

   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_DEV  = 3'b001,
      SER_ID   = 3'b010,
      SER_CHAN = 3'b011,
      SER_STN  = 3'b100
   } cbp_ser_state_t;

   typedef struct packed {
      logic [15:0] comm_lost;
      logic [15:0] type_mismatch;
      logic [15:0] breaker;
      logic [15:0] sdiag;
   } cbp_slave_st_t;

   function automatic logic [15:0] relay_of(input logic [63:0] img);
      logic [15:0] r;
      r = 16'h0000;
      for (int k = 0; k < N_SLAVES; k++) begin
         r[k] = img[4 * k + RELAY_BIT];
      end
      return r;
   endfunction

   function automatic logic [7:0] err_number(input logic com, input logic typ,
                                             input logic brk, input logic sd);
      logic [7:0] e;
      e = ERR_NONE;
      if (com)
         e = ERR_COMM;
      else if (typ)
         e = ERR_TYPE;
      else if (brk)
         e = ERR_BREAKER;
      else if (sd)
         e = ERR_SDIAG;
      return e;
   endfunction

endpackage

// ### core/cbp_diag_ser.sv
`timescale 1ns/10ps
module cbp_diag_ser (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              start,
   input  wire logic              detailed,
   input  wire logic [63:0]       img,
   input  wire logic [63:0]       id_bits,
   input  wire logic [15:0][7:0]  codes,
   output logic                   busy,
   output logic                   dout_valid,
   output logic [7:0]             dout_byte,
   output logic                   dout_last
);
   typedef struct packed {
      cbp_pkg::cbp_ser_state_t st;
      logic [3:0]              idx;
      logic [1:0]              sub;
      logic                    det;
      logic [63:0]             img;
      logic [63:0]             id;
      logic [15:0][7:0]        codes;
      logic [3:0]              last_idx;
      logic                    any;
      logic                    valid;
      logic [7:0]              data;
      logic                    last;
      logic                    busy;
   } cbp_ser_t;

   cbp_ser_t s;
   cbp_ser_t next_s;

   always_comb begin
      next_s       = s;
      next_s.valid = 1'b0;
      next_s.last  = 1'b0;
      case (s.st)
         cbp_pkg::SER_IDLE: begin
            if (start) begin
               next_s.st    = cbp_pkg::SER_DEV;
               next_s.idx   = 4'h0;
               next_s.sub   = 2'h0;
               next_s.det   = detailed;
               next_s.img   = img;
               next_s.id    = id_bits;
               next_s.codes = codes;
               next_s.any   = 1'b0;
               next_s.last_idx = 4'h0;
               for (int k = 0; k < cbp_pkg::N_SLAVES; k++) begin
                  if (codes[k] != cbp_pkg::ERR_NONE) begin
                     next_s.any      = 1'b1;
                     next_s.last_idx = 4'(k);
                  end
               end
            end
         end
         cbp_pkg::SER_DEV: begin
            next_s.valid = 1'b1;
            next_s.data  = s.img[8 * s.idx +: 8];
            next_s.idx   = s.idx + 4'h1;
            if (s.idx == 4'(cbp_pkg::DEV_BYTES - 1)) begin
               // detailed: id bits next; abbreviated: station bytes follow
               next_s.st  = s.det ? cbp_pkg::SER_ID : cbp_pkg::SER_STN;
               next_s.idx = s.det ? 4'h0 : 4'(cbp_pkg::DEV_BYTES);
            end
         end
         cbp_pkg::SER_STN: begin
            next_s.valid = 1'b1;
            next_s.data  = s.img[8 * s.idx +: 8];
            next_s.idx   = s.idx + 4'h1;
            if (s.idx == 4'(cbp_pkg::IMG_BYTES - 1)) begin
               next_s.last = 1'b1;
               next_s.st   = cbp_pkg::SER_IDLE;
            end
         end
         cbp_pkg::SER_ID: begin
            next_s.valid = 1'b1;
            next_s.data  = s.id[8 * s.idx +: 8];
            next_s.idx   = s.idx + 4'h1;
            if (s.idx == 4'(cbp_pkg::ID_BYTES - 1)) begin
               next_s.idx  = 4'h0;
               next_s.last = !s.any;
               next_s.st   = s.any ? cbp_pkg::SER_CHAN : cbp_pkg::SER_IDLE;
            end
         end
         cbp_pkg::SER_CHAN: begin
            // quiet channels are skipped, one cycle each
            if (s.codes[s.idx] == cbp_pkg::ERR_NONE) begin
               next_s.idx = s.idx + 4'h1;
            end else begin
               next_s.valid = 1'b1;
               case (s.sub)
                  2'h0:    next_s.data = 8'({4'h0, s.idx} + 8'h01);
                  2'h1:    next_s.data = cbp_pkg::CHAN_TYPE;
                  default: next_s.data = s.codes[s.idx];
               endcase
               next_s.sub = s.sub + 2'h1;
               if (s.sub == 2'(cbp_pkg::CHAN_BYTES - 1)) begin
                  next_s.sub = 2'h0;
                  next_s.idx = s.idx + 4'h1;
                  if (s.idx == s.last_idx) begin
                     next_s.last = 1'b1;
                     next_s.st   = cbp_pkg::SER_IDLE;
                  end
               end
            end
         end
         default: next_s.st = cbp_pkg::SER_IDLE;
      endcase
      // kept as a flop so the busy output carries no decode logic
      next_s.busy = (next_s.st != cbp_pkg::SER_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign busy       = s.busy;
   assign dout_valid = s.valid;
   assign dout_byte  = s.data;
   assign dout_last  = s.last;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_errno_nonzero: assert property (
      (s.st == cbp_pkg::SER_CHAN && s.sub == 2'h2 && s.codes[s.idx] != cbp_pkg::ERR_NONE)
      |=> (dout_valid && dout_byte != cbp_pkg::ERR_NONE))
      else $error("channel entry without error number");

endmodule

// ### core/cbp_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - output image is exactly eight bytes
// - byte n: low nibble slave 2n-1, high 2n
// - slave numbers follow physical bus position
// - only nibble bit 0 used, rest ignored
// - command bit drives coil: 1 on, 0 off
// - detailed: 2 device, 8 id, 3 per channel
// - channel entry carries an error number
// - abbreviated: device bytes then station bytes
// - byte 1 holds the five module fault bits
// - master fault set only when bus offline
// - comm fault when any slave unreachable
module cbp_top #(
   parameter int ID_SLOT = 0
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        gw_byte_valid,
   input  wire logic        gw_byte_first,
   input  wire logic [7:0]  gw_byte,
   input  wire logic [15:0] slave_comm_lost,
   input  wire logic [15:0] slave_type_mismatch,
   input  wire logic [15:0] breaker_trip_fault,
   input  wire logic [15:0] slave_diag_flag,
   input  wire logic        slave_supply_fault,
   input  wire logic        aux_supply_fault,
   input  wire logic        controller_readiness_fault,
   input  wire logic        slave_bus_offline,
   output logic      [15:0] relay_command_bit,
   output logic             diag_valid,
   output logic      [7:0]  diag_byte,
   output logic             diag_last,
   output logic             diag_busy,
   output logic             irq
);
   typedef struct packed {
      logic [7:0][7:0]            acc;
      logic [2:0]                 cnt;
      logic [15:0]                relay;
      logic                       mode;
      logic                       start;
      logic [cbp_pkg::EV_W-1:0]   status;
      logic [cbp_pkg::EV_W-1:0]   mask;
      logic                       irq;
      logic [31:0]                rdata;
      logic [63:0]                diag;
      logic                       gen_prev;
   } cbp_top_st_t;

   cbp_top_st_t s;
   cbp_top_st_t next_s;

   logic [1:0]  rst_sync;
   logic        rst_n;
   logic        ser_busy;
   logic [63:0] id_bits;
   logic [15:0][7:0] codes;
   logic [7:0]  byte1;
   logic [7:0]  byte2;
   logic        general;
   logic [cbp_pkg::EV_W-1:0] ev;
   logic        comm_any;

   // reset release through two stages, assertion stays asynchronous
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   always_comb begin
      comm_any = |slave_comm_lost;
      general  = slave_supply_fault | comm_any | controller_readiness_fault |
                 slave_bus_offline | aux_supply_fault | (|slave_type_mismatch) |
                 (|breaker_trip_fault) | (|slave_diag_flag);
      byte1 = 8'h00;
      byte1[cbp_pkg::B1_GENERAL]    = general;
      byte1[cbp_pkg::B1_SLV_SUPPLY] = slave_supply_fault;
      byte1[cbp_pkg::B1_COMM]       = comm_any;
      byte1[cbp_pkg::B1_READY]      = controller_readiness_fault;
      byte1[cbp_pkg::B1_MASTER]     = slave_bus_offline;
      byte2 = 8'h00;
      byte2[cbp_pkg::B2_AUX]     = aux_supply_fault;
      byte2[cbp_pkg::B2_TYPE]    = |slave_type_mismatch;
      byte2[cbp_pkg::B2_BREAKER] = |breaker_trip_fault;
      byte2[cbp_pkg::B2_SDIAG]   = |slave_diag_flag;
   end

   always_comb begin
      id_bits          = 64'h0000_0000_0000_0000;
      id_bits[ID_SLOT] = s.diag[cbp_pkg::B1_GENERAL];
      for (int k = 0; k < cbp_pkg::N_SLAVES; k++) begin
         // index k is physical station k+1
         codes[k] = cbp_pkg::err_number(slave_comm_lost[k], slave_type_mismatch[k],
                                        breaker_trip_fault[k], slave_diag_flag[k]);
      end
   end

   always_comb begin
      next_s = s;
      ev     = '0;
      next_s.start = 1'b0;

      // diagnostics image, refreshed every cycle
      next_s.diag = {breaker_trip_fault, slave_diag_flag, slave_type_mismatch,
                     byte2, byte1};
      next_s.gen_prev = general;
      ev[cbp_pkg::EV_FAULT_RISE] = general & ~s.gen_prev;

      // output image assembly; a partial frame is dropped, not applied
      if (gw_byte_valid) begin
         if (gw_byte_first) begin
            next_s.acc[0] = gw_byte;
            next_s.cnt    = 3'h1;
            ev[cbp_pkg::EV_FRAME_ERR] = (s.cnt != 3'h0);
         end else if (s.cnt == 3'h0) begin
            ev[cbp_pkg::EV_FRAME_ERR] = 1'b1;
         end else begin
            next_s.acc[s.cnt] = gw_byte;
            next_s.cnt        = s.cnt + 3'h1;
            if (s.cnt == 3'(cbp_pkg::IMG_BYTES - 1)) begin
               // upper three nibble bits never reach the slaves
               next_s.relay = cbp_pkg::relay_of(next_s.acc);
               ev[cbp_pkg::EV_IMAGE_DONE] = 1'b1;
            end
         end
      end

      ev[cbp_pkg::EV_DIAG_DONE] = diag_valid & diag_last;

      next_s.status = s.status | ev;
      next_s.rdata  = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            cbp_pkg::REG_CTRL: begin
               next_s.mode = reg_wdata[cbp_pkg::CTRL_MODE_BIT];
               // start while a message is running is ignored
               next_s.start = reg_wdata[cbp_pkg::CTRL_START_BIT] & ~ser_busy & ~s.start;
            end
            cbp_pkg::REG_STATUS:
               // new event wins over a clear in the same cycle
               next_s.status = (s.status & ~reg_wdata[cbp_pkg::EV_W-1:0]) | ev;
            cbp_pkg::REG_MASK:
               next_s.mask = reg_wdata[cbp_pkg::EV_W-1:0];
            default: next_s.mask = s.mask;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            cbp_pkg::REG_CTRL:
               next_s.rdata = {30'h0000_0000, ser_busy, s.mode};
            cbp_pkg::REG_STATUS:
               next_s.rdata = {28'h000_0000, s.status};
            cbp_pkg::REG_MASK:
               next_s.rdata = {28'h000_0000, s.mask};
            cbp_pkg::REG_DIAG_LO:
               next_s.rdata = s.diag[31:0];
            cbp_pkg::REG_DIAG_HI:
               next_s.rdata = s.diag[63:32];
            cbp_pkg::REG_RELAY:
               next_s.rdata = {16'h0000, s.relay};
            default:
               next_s.rdata = 32'h0000_0000;
         endcase
      end
      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s      <= '0;
         s.mode <= cbp_pkg::CTRL_MODE_RST;
         s.mask <= cbp_pkg::MASK_RST;
      end else begin
         s <= next_s;
      end
   end

   cbp_diag_ser u_ser (
      .clk        (mclk),
      .rst_n      (rst_n),
      .start      (s.start),
      .detailed   (s.mode),
      .img        (s.diag),
      .id_bits    (id_bits),
      .codes      (codes),
      .busy       (ser_busy),
      .dout_valid (diag_valid),
      .dout_byte  (diag_byte),
      .dout_last  (diag_last)
   );

   assign reg_rdata         = s.rdata;
   assign relay_command_bit = s.relay;
   assign irq               = s.irq;
   assign diag_busy         = ser_busy;

   // message length bookkeeping for the checks below
   logic [7:0] msg_cnt;
   logic       msg_det;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         msg_cnt <= 8'h00;
         msg_det <= 1'b0;
      end else begin
         if (s.start)
            msg_det <= s.mode;
         if (diag_valid)
            msg_cnt <= diag_last ? 8'h00 : msg_cnt + 8'h01;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_commit;
      gw_byte_valid && !gw_byte_first && s.cnt == 3'h7;
   endsequence

   sequence s_msg_end;
      diag_valid && diag_last;
   endsequence

   chk_frame_len: assert property (
      $changed(relay_command_bit) |-> $past(gw_byte_valid && !gw_byte_first && s.cnt == 3'h7))
      else $error("relay image changed without a full eight-byte frame");

   chk_nibble_map: assert property (
      s_commit |=> (relay_command_bit[15] == $past(gw_byte[4]) &&
                    relay_command_bit[14] == $past(gw_byte[0]) &&
                    relay_command_bit[0] == $past(s.acc[0][0]) &&
                    relay_command_bit[1] == $past(s.acc[0][4])))
      else $error("relay command not taken from nibble bit 0");

   chk_byte1_bits: assert property (
      ##1 (s.diag[cbp_pkg::B1_SLV_SUPPLY] == $past(slave_supply_fault) &&
           s.diag[cbp_pkg::B1_READY] == $past(controller_readiness_fault) &&
           s.diag[5] == 1'b0 && s.diag[3] == 1'b0 && s.diag[1] == 1'b0))
      else $error("diagnostics byte 1 layout wrong");

   chk_master_fault: assert property (
      ##1 (s.diag[cbp_pkg::B1_MASTER] == $past(slave_bus_offline)))
      else $error("master fault does not follow bus offline state");

   chk_comm_fault: assert property (
      (|slave_comm_lost) |=> s.diag[cbp_pkg::B1_COMM] && s.diag[cbp_pkg::B1_GENERAL])
      else $error("unreachable slave not flagged as comm fault");

   chk_summary_or: assert property (
      s.diag[8 + cbp_pkg::B2_TYPE] == (|s.diag[31:16]) &&
      s.diag[8 + cbp_pkg::B2_SDIAG] == (|s.diag[47:32]) &&
      s.diag[8 + cbp_pkg::B2_BREAKER] == (|s.diag[63:48]))
      else $error("summary bit disagrees with per-slave flags");

   chk_slave_order: assert property (
      ##1 (s.diag[31:16] == $past(slave_type_mismatch) &&
           s.diag[47:32] == $past(slave_diag_flag) &&
           s.diag[63:48] == $past(breaker_trip_fault)))
      else $error("per-slave diagnostics flags out of order");

   chk_detail_len: assert property (
      s_msg_end ##0 msg_det |-> (msg_cnt >= 8'd9 && ((msg_cnt - 8'd9) % 8'd3) == 8'd0))
      else $error("detailed message length not 10 plus 3n");

   chk_abbr_len: assert property (
      s_msg_end ##0 !msg_det |-> msg_cnt == 8'd7)
      else $error("abbreviated message not eight bytes");

endmodule

// ### test/cbp_gw_model.sv
`timescale 1ns/10ps
module cbp_gw_model (
   input  wire logic        mclk,
   output logic             gw_byte_valid,
   output logic             gw_byte_first,
   output logic      [7:0]  gw_byte
);
   initial begin
      gw_byte_valid = 1'b0;
      gw_byte_first = 1'b0;
      gw_byte       = 8'h00;
   end

   // n below 8 or no first marker makes a broken frame on purpose
   task automatic send(input logic [63:0] img, input int n, input logic with_first);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         gw_byte_valid <= 1'b1;
         gw_byte_first <= with_first && (i == 0);
         gw_byte       <= img[8 * i +: 8];
      end
      @(posedge mclk);
      gw_byte_valid <= 1'b0;
      gw_byte_first <= 1'b0;
      // idle byte lane never repeats the last value
      gw_byte       <= ~gw_byte;
   endtask
endmodule

// ### test/test_cbp_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); n_fail++; end end
module test_cbp_top;
   localparam int ID_SLOT = 5;
   logic        mclk;
   logic        nrst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        gw_byte_valid;
   logic        gw_byte_first;
   logic [7:0]  gw_byte;
   logic [15:0] slave_comm_lost;
   logic [15:0] slave_type_mismatch;
   logic [15:0] breaker_trip_fault;
   logic [15:0] slave_diag_flag;
   logic        slave_supply_fault;
   logic        aux_supply_fault;
   logic        controller_readiness_fault;
   logic        slave_bus_offline;
   logic [15:0] relay_command_bit;
   logic        diag_valid;
   logic [7:0]  diag_byte;
   logic        diag_last;
   logic        diag_busy;
   logic        irq;
   int          n_fail;
   int          tests_run;
   int          cycles;
   logic [7:0]  got_q[$];
   logic [7:0]  exp_q[$];
   logic [63:0] imgs[3];
   logic [15:0] exp_relay;

   cbp_top #(.ID_SLOT(ID_SLOT)) u_cbp_top (
      .mclk                       (mclk),
      .nrst                       (nrst),
      .reg_addr                   (reg_addr),
      .reg_wdata                  (reg_wdata),
      .reg_wr                     (reg_wr),
      .reg_rd                     (reg_rd),
      .reg_rdata                  (reg_rdata),
      .gw_byte_valid              (gw_byte_valid),
      .gw_byte_first              (gw_byte_first),
      .gw_byte                    (gw_byte),
      .slave_comm_lost            (slave_comm_lost),
      .slave_type_mismatch        (slave_type_mismatch),
      .breaker_trip_fault         (breaker_trip_fault),
      .slave_diag_flag            (slave_diag_flag),
      .slave_supply_fault         (slave_supply_fault),
      .aux_supply_fault           (aux_supply_fault),
      .controller_readiness_fault (controller_readiness_fault),
      .slave_bus_offline          (slave_bus_offline),
      .relay_command_bit          (relay_command_bit),
      .diag_valid                 (diag_valid),
      .diag_byte                  (diag_byte),
      .diag_last                  (diag_last),
      .diag_busy                  (diag_busy),
      .irq                        (irq)
   );

   cbp_gw_model u_cbp_gw_model (
      .mclk          (mclk),
      .gw_byte_valid (gw_byte_valid),
      .gw_byte_first (gw_byte_first),
      .gw_byte       (gw_byte)
   );

   always #25 mclk = ~mclk;

   always @(posedge mclk) begin
      if (diag_valid === 1'b1)
         got_q.push_back(diag_byte);
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic close_out;
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      `CHK(nm, e, reg_rdata)
   endtask

   // expected message worked out from the fault inputs, then the stream compared
   task automatic run_diag(input logic det);
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic [63:0] dv;
      logic [63:0] id;
      logic        gen;
      logic [7:0]  code;
      gen = |{slave_comm_lost, slave_type_mismatch, breaker_trip_fault, slave_diag_flag,
              slave_supply_fault, aux_supply_fault, controller_readiness_fault,
              slave_bus_offline};
      b1 = {gen, slave_supply_fault, 1'b0, |slave_comm_lost, 1'b0,
            controller_readiness_fault, 1'b0, slave_bus_offline};
      b2 = {1'b0, aux_supply_fault, |slave_type_mismatch, 1'b0, |breaker_trip_fault,
            1'b0, |slave_diag_flag, 1'b0};
      dv = {breaker_trip_fault, slave_diag_flag, slave_type_mismatch, b2, b1};
      id = 64'(gen) << ID_SLOT;
      exp_q = {};
      got_q = {};
      for (int i = 0; i < 8; i++)
         exp_q.push_back((det && i > 1) ? id[8 * (i - 2) +: 8] : dv[8 * i +: 8]);
      if (det) begin
         exp_q.push_back(id[55:48]);
         exp_q.push_back(id[63:56]);
         for (int k = 0; k < 16; k++) begin
            code = slave_comm_lost[k] ? cbp_pkg::ERR_COMM :
                   slave_type_mismatch[k] ? cbp_pkg::ERR_TYPE :
                   breaker_trip_fault[k] ? cbp_pkg::ERR_BREAKER :
                   slave_diag_flag[k] ? cbp_pkg::ERR_SDIAG : cbp_pkg::ERR_NONE;
            if (code !== cbp_pkg::ERR_NONE) begin
               exp_q.push_back(8'(k + 1));
               exp_q.push_back(cbp_pkg::CHAN_TYPE);
               exp_q.push_back(code);
            end
         end
      end
      wr(cbp_pkg::REG_CTRL, {30'h0, 1'b1, det});
      @(posedge mclk);
      #1;
      `CHK("busy in message", 1'b1, diag_busy)
      for (int c = 0; c < 200; c++) begin
         @(posedge mclk);
         if (diag_last === 1'b1)
            break;
      end
      #1;
      `CHK("diag length", exp_q.size(), got_q.size())
      for (int i = 0; i < exp_q.size(); i++)
         `CHK("diag byte", exp_q[i], got_q[i])
   endtask

   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      {slave_comm_lost, slave_type_mismatch, breaker_trip_fault, slave_diag_flag} = 64'h0;
      {slave_supply_fault, aux_supply_fault} = 2'h0;
      {controller_readiness_fault, slave_bus_offline} = 2'h0;
      n_fail = 0;
      tests_run = 0;
      cycles = 0;
      imgs = '{64'hFEDCBA9876543210, 64'hEEEEEEEEEEEEEEEF, 64'h1111111111111110};
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK("relay after reset", 16'h0000, relay_command_bit)
      rd_chk(cbp_pkg::REG_CTRL, 32'h0, "ctrl");
      rd_chk(cbp_pkg::REG_STATUS, 32'h0, "status");
      rd_chk(cbp_pkg::REG_MASK, 32'h0, "mask");
      rd_chk(8'h18, 32'h0, "unmapped");
      // upper nibble bits carry noise that must not reach any coil
      foreach (imgs[j]) begin
         for (int k = 0; k < 16; k++)
            exp_relay[k] = imgs[j][4 * k];
         u_cbp_gw_model.send(imgs[j], 8, 1'b1);
         #1;
         `CHK("relay", exp_relay, relay_command_bit)
         rd_chk(cbp_pkg::REG_RELAY, {16'h0, exp_relay}, "relay reg");
      end
      rd_chk(cbp_pkg::REG_STATUS, 32'h2, "image done");
      wr(cbp_pkg::REG_STATUS, 32'hF);
      u_cbp_gw_model.send(64'hFFFFFFFFFFFFFFFF, 3, 1'b1);
      `CHK("partial frame", 16'hFFFE, relay_command_bit)
      u_cbp_gw_model.send(imgs[0], 8, 1'b1);
      #1;
      `CHK("relay after restart", 16'hAAAA, relay_command_bit)
      rd_chk(cbp_pkg::REG_STATUS, 32'h3, "frame error");
      wr(cbp_pkg::REG_STATUS, 32'hF);
      u_cbp_gw_model.send(64'h1, 1, 1'b0);
      rd_chk(cbp_pkg::REG_STATUS, 32'h1, "stray byte");
      `CHK("relay kept", 16'hAAAA, relay_command_bit)
      wr(cbp_pkg::REG_STATUS, 32'hF);
      wr(cbp_pkg::REG_MASK, 32'h4);
      @(posedge mclk);
      slave_comm_lost <= 16'h0004;
      slave_type_mismatch <= 16'h0014;
      breaker_trip_fault <= 16'h8000;
      slave_diag_flag <= 16'h0100;
      {slave_supply_fault, aux_supply_fault} <= 2'h3;
      {controller_readiness_fault, slave_bus_offline} <= 2'h3;
      repeat (2) @(posedge mclk);
      run_diag(1'b0);
      rd_chk(cbp_pkg::REG_DIAG_LO, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]}, "diag lo");
      rd_chk(cbp_pkg::REG_DIAG_HI, {exp_q[7], exp_q[6], exp_q[5], exp_q[4]}, "diag hi");
      rd_chk(cbp_pkg::REG_STATUS, 32'hC, "diag events");
      `CHK("irq raised", 1'b1, irq)
      wr(cbp_pkg::REG_STATUS, 32'h4);
      @(posedge mclk);
      #1;
      `CHK("irq cleared", 1'b0, irq)
      rd_chk(cbp_pkg::REG_STATUS, 32'h8, "masked event kept");
      run_diag(1'b1);
      @(posedge mclk);
      {slave_comm_lost, slave_type_mismatch, breaker_trip_fault, slave_diag_flag} <= 64'h0;
      {slave_supply_fault, aux_supply_fault} <= 2'h0;
      {controller_readiness_fault, slave_bus_offline} <= 2'h0;
      repeat (2) @(posedge mclk);
      run_diag(1'b1);
      run_diag(1'b0);
      `CHK("busy after message", 1'b0, diag_busy)
      close_out();
   end
endmodule
